//--- hw/sitc_mem.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Interval memory, one write port, registered read port
// ----------------------------------------------------------------
module sitc_mem #(
  parameter int W = 32,
  parameter int DEPTH = 2046,
  parameter int AW = 11
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem [DEPTH];

  // No reset on the array; read data is valid one edge after raddr
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

//--- hw/sitc_params.svh
`ifndef SITC_PARAMS_SVH
`define SITC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ----------------------------------------------------------------
`define SITC_OFF_CTRL 8'h00
`define SITC_OFF_CHECK 8'h04
`define SITC_OFF_TRIG 8'h08
`define SITC_OFF_STATUS 8'h0C
`define SITC_OFF_RIDX 8'h10
`define SITC_OFF_RVAL 8'h14
`define SITC_OFF_RINFO 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SITC_CTRL_RUN 0
`define SITC_CTRL_QUAL 1
`define SITC_CTRL_PULSE 2
`define SITC_CTRL_CUM 3
`define SITC_CTRL_UNIT 4
`define SITC_CTRL_CLEAR 8
`define SITC_STAT_WADDR 16
`define SITC_STAT_RUN 31
`define SITC_INFO_BUSY 0
`define SITC_INFO_OVF 1
`define SITC_INFO_UNIT 2

// ----------------------------------------------------------------
// Reset values and the automatic unit code
// ----------------------------------------------------------------
`define SITC_CTRL_RST 32'h0000_0000
`define SITC_CHECK_RST 32'hFFFF_FFFF
`define SITC_UNIT_AUTO 2'h3

// ----------------------------------------------------------------
// Timing (picoseconds) and derived counts
// ----------------------------------------------------------------
`define SITC_PCLK_PS 16'h1F40
`define SITC_TICK_PS 16'h2710
`define SITC_SAMPLE_PS 16'h4E20
`define SITC_MIN_GAP_PS 16'h9C40
`define SITC_GAP_CYC ((`SITC_MIN_GAP_PS + `SITC_PCLK_PS - 16'h0001) / `SITC_PCLK_PS)
`define SITC_WIN_SMP (`SITC_MIN_GAP_PS / `SITC_SAMPLE_PS)

// ----------------------------------------------------------------
// Capacity and scaling
// ----------------------------------------------------------------
`define SITC_DEPTH 2046
`define SITC_CNT_W 32
`define SITC_DIV_US 40'h00_0000_0064
`define SITC_DIV_MS 40'h00_0001_86A0
`define SITC_DIV_S 40'h00_05F5_E100
`define SITC_DIV_ONE 40'h00_0000_0001
`define SITC_DIV_K 40'h00_0000_03E8
`define SITC_DIV_M 40'h00_000F_4240
`define SITC_DISP_MAX 40'h00_0000_270F

`endif

//--- hw/sitc_pkg.sv
package sitc_pkg;

  // ----------------------------------------------------------------
  // Shared types
  // ----------------------------------------------------------------
  typedef logic [31:0] sitc_word_t;

  // Readout sequencer, Gray coded along idle -> walk -> divide
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_WALK = 2'b01,
    RD_DIV = 2'b11
  } sitc_rd_state_t;

endpackage

//--- hw/sitc_top.sv
// Notes on behaviour
// RULE_01: Transition mode stores time since previous transition
// RULE_02: Counter limit sets longest interval, about 42.949 s
// RULE_03: Recordings 40 ns apart; crowded transitions dropped
// RULE_04: Transition mode samples pods on 50 MHz tick
// RULE_05: Unchecked pods never trigger; stored with recorded word
// RULE_06: Qualified mode counts time ticks or external cycles
// RULE_07: Qualified mode stores interval since previous word
// RULE_08: Target qualified clock stays at or below 25 MHz
// RULE_09: Cumulative view sums from trigger; delta view raw
// RULE_10: Pulse scales one, thousand, million, or automatic
// RULE_11: Value too large for unit gets overflow flag
// RULE_12: 32-bit counter on 100 MHz ticks or external clock
// RULE_13: Counter written at word address, then restarted
// RULE_14: 2046 entries, one write per 40 ns at most
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "sitc_params.svh"

module sitc_top #(
  parameter int NPODS = 4,
  parameter int POD_W = 8,
  parameter int DEPTH = `SITC_DEPTH,
  parameter int AW = 11
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire sitc_pkg::sitc_word_t pwdata,
  output sitc_pkg::sitc_word_t prdata,
  output logic pready,
  output logic pslverr,
  // Probe link
  input wire logic probe_clk,
  input wire logic qual_in,
  input wire logic [NPODS*POD_W-1:0] probe_data,
  // Acquisition memory write side
  output logic acq_we,
  output logic [AW-1:0] acq_addr,
  output logic [NPODS*POD_W-1:0] acq_data
);
  import sitc_pkg::*;

  localparam int DW = NPODS * POD_W;
  localparam int SW = DW + 2;
  localparam int CW = `SITC_CNT_W;
  localparam int SUMW = 40;
  localparam logic [15:0] GAP_CYC = 16'(`SITC_GAP_CYC);
  localparam logic [1:0] WIN_SMP = 2'(`SITC_WIN_SMP);

  typedef struct packed {
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic [SW-1:0] s3;
    logic [SW-1:0] sf;
    logic q_last;
    logic e_last;
    logic [15:0] acc_t;
    logic [15:0] acc_s;
    logic [DW-1:0] pod_prev;
    logic [DW-1:0] win_word;
    logic [1:0] win_cnt;
    logic win_bad;
    logic [CW-1:0] cnt;
    logic [15:0] gap;
    logic [AW-1:0] waddr;
    logic [AW:0] stored;
    logic run;
    logic qual;
    logic pulse;
    logic cum;
    logic [1:0] unit;
    logic [NPODS-1:0] check;
    logic [AW-1:0] trig;
    logic [AW-1:0] ridx;
    sitc_rd_state_t rd;
    logic [AW-1:0] rd_addr;
    logic [AW-1:0] rd_end;
    logic [1:0] rd_ph;
    logic [SUMW-1:0] sum;
    logic [SUMW-1:0] div_q;
    logic [SUMW-1:0] div_r;
    logic [5:0] div_n;
    logic [1:0] cur_unit;
    logic [31:0] res_val;
    logic res_ovf;
    logic [1:0] res_unit;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic acq_we;
    logic [AW-1:0] acq_addr;
    logic [DW-1:0] acq_data;
    logic mem_we;
    logic [AW-1:0] mem_waddr;
    logic [AW-1:0] mem_raddr;
    logic [CW-1:0] mem_wdata;
  } sitc_state_t;

  typedef struct packed {
    logic q_tgl;
    logic e_tgl;
    logic [DW-1:0] hold;
  } sitc_link_t;

  sitc_state_t r;
  sitc_state_t n;
  sitc_link_t l;
  sitc_link_t ln;
  logic [DW-1:0] chk_x;
  logic [CW-1:0] mem_rdata;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Register decode: bit 3 is the hit flag, bits 2:0 the register
  function automatic logic [3:0] sitc_decode(input logic [7:0] a);
    logic [3:0] d;
    d = 4'h0;
    if (a[1:0] == 2'h0 && a[7:5] == 3'h0 && a[4:2] != 3'h7) begin
      d = {1'b1, a[4:2]};
    end
    return d;
  endfunction

  // Unit divisor; time ticks are 10 ns, pulse scales are plain counts
  function automatic logic [SUMW-1:0] sitc_divisor(input logic pulse, input logic [1:0] u);
    logic [SUMW-1:0] d;
    d = pulse ? `SITC_DIV_ONE : `SITC_DIV_US;
    if (u == 2'h1) begin
      d = pulse ? `SITC_DIV_K : `SITC_DIV_MS;
    end else if (u == 2'h2) begin
      d = pulse ? `SITC_DIV_M : `SITC_DIV_S;
    end
    return d;
  endfunction

  // Pod check mask widened to one bit per channel
  for (genvar g = 0; g < NPODS; g++) begin : g_chk
    assign chk_x[g*POD_W +: POD_W] = {POD_W{r.check[g]}};
  end

  // ----------------------------------------------------------------
  // Link domain: probe clock
  // ----------------------------------------------------------------

  // Each probe edge flips e_tgl; a qualified edge flips q_tgl and holds
  // the word, which stays put for at least 40 ns so pclk can take it
  always_comb begin
    ln = l;
    ln.e_tgl = ~l.e_tgl;
    if (qual_in) begin
      ln.q_tgl = ~l.q_tgl;
      ln.hold = probe_data;
    end
  end

  always_ff @(posedge probe_clk or negedge presetn) begin
    if (!presetn) begin
      l <= '0;
    end else begin
      l <= ln;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: pclk
  // ----------------------------------------------------------------

  // Sync, ticks, recording, APB and readout in one next-state process
  always_comb begin
    logic [DW-1:0] pods;
    logic q_ev;
    logic e_ev;
    logic [15:0] t_sum;
    logic [15:0] s_sum;
    logic tick;
    logic smp;
    logic chg;
    logic win_ok;
    logic rec;
    logic inc;
    logic [3:0] dec;
    logic [31:0] rv;
    logic wr;
    logic [AW-1:0] widx;
    logic [SUMW-1:0] acc;
    logic [SUMW:0] t41;
    logic [SUMW-1:0] dv;
    logic ge;
    logic [SUMW-1:0] qv;
    logic ovf;
    pods = '0;
    q_ev = 1'b0;
    e_ev = 1'b0;
    t_sum = '0;
    s_sum = '0;
    tick = 1'b0;
    smp = 1'b0;
    chg = 1'b0;
    win_ok = 1'b0;
    rec = 1'b0;
    inc = 1'b0;
    dec = '0;
    rv = '0;
    wr = 1'b0;
    widx = '0;
    acc = '0;
    t41 = '0;
    dv = '0;
    ge = 1'b0;
    qv = '0;
    ovf = 1'b0;
    n = r;
    n.mem_we = 1'b0;
    n.acq_we = 1'b0;

    // Three-stage sync; a bit moves only once stages two and three agree
    n.s1 = {l.e_tgl, l.q_tgl, probe_data};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.sf = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.sf);
    pods = r.sf[DW-1:0];
    q_ev = r.sf[DW] ^ r.q_last;
    e_ev = r.sf[DW+1] ^ r.e_last;
    n.q_last = r.sf[DW];
    n.e_last = r.sf[DW+1];

    // Phase accumulators: 10 ns and 20 ns ticks from an 8 ns clock,
    // exact on average at the cost of one pclk of jitter per tick
    t_sum = r.acc_t + `SITC_PCLK_PS;
    tick = t_sum >= `SITC_TICK_PS; // RULE_12
    n.acc_t = tick ? t_sum - `SITC_TICK_PS : t_sum;
    s_sum = r.acc_s + `SITC_PCLK_PS;
    smp = s_sum >= `SITC_SAMPLE_PS; // RULE_04
    n.acc_s = smp ? s_sum - `SITC_SAMPLE_PS : s_sum;

    // Transition window: a second checked change inside it kills the word
    chg = |((pods ^ r.pod_prev) & chk_x); // RULE_05
    if (smp) begin
      n.pod_prev = pods;
      if (r.win_cnt == 2'h0) begin
        if (chg) begin
          n.win_cnt = WIN_SMP; // RULE_03
          n.win_bad = 1'b0;
          n.win_word = pods; // RULE_05
        end
      end else begin
        n.win_cnt = r.win_cnt - 2'h1;
        if (chg) begin
          n.win_bad = 1'b1; // RULE_03
        end
        win_ok = (r.win_cnt == 2'h1) && !r.win_bad && !chg; // RULE_03
      end
    end
    if (!r.run || r.qual) begin
      n.win_cnt = 2'h0;
    end

    // Record: qualified edge or clean transition, spaced by the gap counter
    rec = r.run && (r.qual ? q_ev : win_ok) && (r.gap == 16'h0000); // RULE_14 RULE_08
    inc = (r.qual && r.pulse) ? e_ev : tick; // RULE_06
    n.gap = (r.gap != 16'h0000) ? r.gap - 16'h0001 : 16'h0000;
    if (r.run && r.cnt != '1) begin
      n.cnt = r.cnt + CW'(inc); // RULE_02
    end
    if (rec) begin
      n.mem_we = 1'b1;
      n.mem_waddr = r.waddr;
      n.mem_wdata = r.cnt; // RULE_13 RULE_01 RULE_07
      n.acq_we = 1'b1;
      n.acq_addr = r.waddr;
      n.acq_data = r.qual ? l.hold : r.win_word;
      n.cnt = CW'(inc); // RULE_13
      n.waddr = (r.waddr == AW'(DEPTH - 1)) ? '0 : r.waddr + AW'(1); // RULE_14
      n.stored = (r.stored == (AW + 1)'(DEPTH)) ? r.stored : r.stored + (AW + 1)'(1);
      n.gap = GAP_CYC - 16'h0001; // RULE_14
    end

    // APB: answer in the first access cycle, data set up during setup
    dec = sitc_decode(paddr);
    case (dec[2:0])
      3'h0: begin
        rv[`SITC_CTRL_RUN] = r.run;
        rv[`SITC_CTRL_QUAL] = r.qual;
        rv[`SITC_CTRL_PULSE] = r.pulse;
        rv[`SITC_CTRL_CUM] = r.cum;
        rv[`SITC_CTRL_UNIT +: 2] = r.unit;
      end
      3'h1: rv[NPODS-1:0] = r.check;
      3'h2: rv[AW-1:0] = r.trig;
      3'h3: begin
        rv[AW:0] = r.stored;
        rv[`SITC_STAT_WADDR +: AW] = r.waddr;
        rv[`SITC_STAT_RUN] = r.run;
      end
      3'h4: rv[AW-1:0] = r.ridx;
      3'h5: rv = r.res_val;
      default: begin
        rv[`SITC_INFO_BUSY] = r.rd != RD_IDLE;
        rv[`SITC_INFO_OVF] = r.res_ovf; // RULE_11
        rv[`SITC_INFO_UNIT +: 2] = r.res_unit;
      end
    endcase
    n.pready = psel && !penable;
    n.prdata = (psel && !penable) ? (dec[3] ? rv : 32'h0000_0000) : r.prdata;
    n.pslverr = psel && !penable && !dec[3];
    wr = psel && penable && r.pready && pwrite && dec[3];
    widx = pwdata[AW-1:0];
    if (wr && dec[2:0] == 3'h0) begin
      n.run = pwdata[`SITC_CTRL_RUN];
      n.qual = pwdata[`SITC_CTRL_QUAL];
      n.pulse = pwdata[`SITC_CTRL_PULSE];
      n.cum = pwdata[`SITC_CTRL_CUM];
      n.unit = pwdata[`SITC_CTRL_UNIT +: 2];
      if (pwdata[`SITC_CTRL_CLEAR]) begin
        n.cnt = '0;
        n.waddr = '0;
        n.stored = '0;
        n.win_cnt = 2'h0;
      end
    end
    if (wr && dec[2:0] == 3'h1) begin
      n.check = pwdata[NPODS-1:0];
    end
    if (wr && dec[2:0] == 3'h2) begin
      n.trig = widx;
    end

    // Readout: start on an index write while idle and in range
    unique case (r.rd)
      RD_IDLE: begin
        if (wr && dec[2:0] == 3'h4 && widx < AW'(DEPTH)) begin
          n.ridx = widx;
          n.sum = '0;
          n.rd_ph = 2'h0;
          n.cur_unit = (r.unit == `SITC_UNIT_AUTO) ? 2'h0 : r.unit;
          n.rd = RD_WALK;
          n.rd_addr = widx;
          n.rd_end = widx;
          if (r.cum && widx > r.trig) begin
            n.rd_addr = r.trig + AW'(1); // RULE_09
          end else if (r.cum && widx < r.trig) begin
            n.rd_addr = widx + AW'(1);
            n.rd_end = r.trig; // RULE_09
          end else if (r.cum) begin
            n.rd = RD_DIV;
            n.div_q = '0;
            n.div_r = '0;
            n.div_n = '0;
          end
        end
      end
      RD_WALK: begin
        n.rd_ph = r.rd_ph + 2'h1;
        if (r.rd_ph == 2'h0) begin
          n.mem_raddr = r.rd_addr;
        end else if (r.rd_ph == 2'h2) begin
          acc = r.sum + SUMW'(mem_rdata); // RULE_09
          n.sum = acc;
          n.rd_ph = 2'h0;
          n.rd_addr = r.rd_addr + AW'(1);
          if (r.rd_addr == r.rd_end) begin
            n.rd = RD_DIV;
            n.div_q = acc;
            n.div_r = '0;
            n.div_n = '0;
          end
        end
      end
      RD_DIV: begin
        // Restoring divide, one quotient bit per cycle
        dv = sitc_divisor(r.pulse && r.qual, r.cur_unit); // RULE_10
        t41 = {r.div_r, r.div_q[SUMW-1]};
        ge = t41 >= {1'b0, dv};
        n.div_r = ge ? SUMW'(t41 - {1'b0, dv}) : t41[SUMW-1:0];
        n.div_q = {r.div_q[SUMW-2:0], ge};
        n.div_n = r.div_n + 6'h01;
        if (r.div_n == 6'(SUMW - 1)) begin
          qv = {r.div_q[SUMW-2:0], ge};
          ovf = qv > `SITC_DISP_MAX; // RULE_11
          if (r.unit == `SITC_UNIT_AUTO && ovf && r.cur_unit != 2'h2) begin
            n.cur_unit = r.cur_unit + 2'h1; // RULE_10
            n.div_q = r.sum;
            n.div_r = '0;
            n.div_n = '0;
          end else begin
            n.res_val = qv[31:0];
            n.res_ovf = ovf; // RULE_11
            n.res_unit = r.cur_unit;
            n.rd = RD_IDLE;
          end
        end
      end
      // Code 2'b10 is never entered; fall back to idle if it ever is
      default: n.rd = RD_IDLE;
    endcase
  end

  // Single state register for the core domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.check <= NPODS'(`SITC_CHECK_RST);
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Interval memory and outputs
  // ----------------------------------------------------------------
  sitc_mem #(
    .W(CW),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk(pclk),
    .we(r.mem_we),
    .waddr(r.mem_waddr),
    .wdata(r.mem_wdata),
    .raddr(r.mem_raddr),
    .rdata(mem_rdata)
  );

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign acq_we = r.acq_we;
  assign acq_addr = r.acq_addr;
  assign acq_data = r.acq_data;

endmodule

//--- sim/sample_interval_timestamp_capture_tb.sv
`timescale 1ns/1ps
`include "sitc_params.svh"
module sample_interval_timestamp_capture_tb;
  import sitc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic probe_clk, qual_in, acq_we, en;
  logic [7:0] paddr;
  logic [10:0] acq_addr;
  logic [31:0] probe_data, acq_data, pod_word, w;
  sitc_word_t pwdata, prdata, rd, info;
  logic [31:0] a_word[$];
  int a_addr[$];
  int num_errors, checks, n, t, u, j, ix;

  // ----------------------------------------------------------------
  // Clock, design and target
  // ----------------------------------------------------------------
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  sitc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .probe_clk(probe_clk), .qual_in(qual_in), .probe_data(probe_data),
    .acq_we(acq_we), .acq_addr(acq_addr), .acq_data(acq_data));
  sitc_probe_model model_u (.en(en), .pod_word(pod_word), .probe_clk(probe_clk),
    .qual_in(qual_in), .probe_data(probe_data));

  // Words as they leave for acquisition memory
  always @(posedge pclk) begin
    if (acq_we === 1'b1) begin
      a_word.push_back(acq_data);
      a_addr.push_back(int'(acq_addr));
    end
  end

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen
  task apb(input logic wr, input logic [7:0] a, input sitc_word_t d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk(32'(k < 20), 32'h1, "pready wait");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Convert one entry; a new index is refused while busy, so wait it out
  task entry(input int idx);
    int k;
    apb(1'b1, `SITC_OFF_RIDX, 32'(idx));
    k = 0;
    do begin
      apb(1'b0, `SITC_OFF_RINFO, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 200);
    chk(32'(k < 200), 32'h1, "busy wait");
    info = rd;
    apb(1'b0, `SITC_OFF_RVAL, 32'h0);
  endtask

  // Distance to the trigger in counted cycles
  function automatic int cum(input int idx, input int tr);
    int r = 0;
    for (int k = (idx < tr ? idx : tr) + 1; k <= (idx < tr ? tr : idx); k++) begin
      r += model_u.q_gap[k];
    end
    return r;
  endfunction

  task print_verdict;
    $display("Checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Tests need some 4k cycles; a hang is cut well beyond
  initial begin
    #400000;
    num_errors++;
    $display("Error at %0t: watchdog", $time);
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, en, pod_word, presetn} = '0;
    void'($urandom(72086));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SITC_OFF_CTRL, 32'h0);
    chk(rd, `SITC_CTRL_RST, "ctrl reset");
    apb(1'b0, `SITC_OFF_CHECK, 32'h0);
    chk(rd, 32'h0000_000F, "check reset");
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    chk(32'(err), 32'h1, "unmapped write");
    apb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    $display("Test registers done");

    // Pulse counting on qualified edges
    apb(1'b1, `SITC_OFF_CTRL, 32'h0000_0007);
    en <= 1'b1;
    repeat (400) @(posedge pclk);
    en <= 1'b0;
    repeat (40) @(posedge pclk);
    apb(1'b1, `SITC_OFF_CTRL, 32'h0000_0006);
    n = model_u.q_word.size();
    chk(a_word.size(), n, "record count");
    for (int i = 0; i < n; i++) begin
      chk(a_word[i], model_u.q_word[i], "qualified word");
      chk(a_addr[i], i, "record address");
    end
    apb(1'b0, `SITC_OFF_STATUS, 32'h0);
    chk({rd[11:0], 5'h0, rd[26:16]}, {12'(n), 5'h0, 11'(n)}, "status");
    for (int i = 1; i < n; i++) begin
      entry(i);
      chk(rd, model_u.q_gap[i], "pulse delta");
    end
    $display("Test qualified done");

    // Cumulative view at every scale
    t = $urandom_range(n - 2, 1);
    apb(1'b1, `SITC_OFF_TRIG, 32'(t));
    for (u = 0; u < 4; u++) begin
      apb(1'b1, `SITC_OFF_CTRL, 32'h0000_000E | 32'(u << 4));
      for (j = 0; j < 3; j++) begin
        ix = (j == 0) ? 0 : (j == 1) ? t : n - 1;
        entry(ix);
        w = (u == 1) ? cum(ix, t) / 1000 : (u == 2) ? cum(ix, t) / 1000000 : cum(ix, t);
        chk(rd, w, "cumulative value");
        chk(info[3:1], {2'((u == 3) ? 0 : u), 1'b0}, "unit and overflow");
      end
    end
    $display("Test cumulative done");

    // Transition recording on pod 0 only
    apb(1'b1, `SITC_OFF_CHECK, 32'h1);
    apb(1'b1, `SITC_OFF_CTRL, 32'h0000_0001);
    repeat (30) @(posedge pclk);
    n = a_word.size();
    pod_word <= 32'h0000_5A00;
    repeat (30) @(posedge pclk);
    chk(a_word.size(), n, "unchecked pod");
    w = 32'h0000_5A00;
    for (int i = 0; i < 5; i++) begin
      w = w ^ 32'(1 << $urandom_range(7, 0));
      pod_word <= w;
      repeat ((i == 2) ? 1300 : 30 + $urandom_range(40, 0)) @(posedge pclk);
    end
    chk(a_word.size(), n + 5, "transition count");
    chk(a_word[$], w, "held pods");
    pod_word <= w ^ 32'h1;
    // 24 ns apart: two distinct 20 ns samples, yet inside one 40 ns span
    repeat (3) @(posedge pclk);
    pod_word <= w ^ 32'h3;
    repeat (40) @(posedge pclk);
    chk(a_word.size(), n + 5, "crowded transitions");
    // Stop and clear in one write; stored intervals stay readable
    apb(1'b1, `SITC_OFF_CTRL, 32'h0000_0100);
    entry(n + 3);
    chk(rd, 32'h0000_000A, "interval in us");
    apb(1'b0, `SITC_OFF_STATUS, 32'h0);
    chk(rd, 32'h0, "cleared status");
    $display("Test transition done");
    print_verdict();
  end
endmodule

//--- sim/sitc_probe_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Probed target: gated link clock, qualifier and pod pins
// ----------------------------------------------------------------
module sitc_probe_model (
  // Bench control
  input wire logic en,
  input wire logic [31:0] pod_word,
  // Target pins
  output logic probe_clk,
  output logic qual_in,
  output logic [31:0] probe_data
);
  int gap;
  logic [31:0] q_word[$];
  int q_gap[$];

  // Clock runs only inside frames; 8 MHz stays under the qualified limit
  initial begin
    probe_clk = 1'b0;
    qual_in = 1'b0;
    probe_data = 32'h0000_0000;
    gap = 0;
    #3.1;
    forever begin
      #62.5;
      if (en || probe_clk) begin
        probe_clk = ~probe_clk;
      end
    end
  end

  // Each edge counts; a qualified edge closes the interval
  always @(posedge probe_clk) begin
    gap = gap + 1;
    if (qual_in) begin
      q_word.push_back(probe_data);
      q_gap.push_back(gap);
      gap = 0;
    end
  end

  // Pins move away from the sampling edge
  always @(negedge probe_clk) begin
    qual_in = 1'($urandom_range(1, 0));
    // The closing fall of a frame must leave the bench's pod levels in place
    probe_data = en ? $urandom : pod_word;
  end

  // Outside frames the bench sets the pod levels
  always @(pod_word or en) begin
    if (!en) begin
      probe_data = pod_word;
    end
  end
endmodule

//--- sim/sitc_top_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checks: APB answer and acquisition write side
// ----------------------------------------------------------------
module sitc_top_assertions #(
  parameter int NPODS = 4,
  parameter int POD_W = 8,
  parameter int DEPTH = 2046,
  parameter int AW = 11
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire sitc_pkg::sitc_word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Acquisition side
  input wire logic acq_we,
  input wire logic [AW-1:0] acq_addr,
  input wire logic [NPODS*POD_W-1:0] acq_data
);
  import sitc_pkg::*;
  logic [AW-1:0] exp_addr_reg;

  // Expected address of the next record; wraps after the last entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_addr_reg <= '0;
    end else if (acq_we) begin
      exp_addr_reg <= (acq_addr == AW'(DEPTH - 1)) ? '0 : acq_addr + AW'(1);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus and record steps
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence quiet_s;
    !acq_we [*4];
  endsequence

  setup_answer_a: assert property (setup_s |=> pready)
    else $error("no pready after setup");
  ready_single_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside one access cycle");
  error_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_moves_a: assert property ($changed(prdata) |-> pready)
    else $error("prdata changed outside access");
  record_gap_a: assert property (acq_we |=> quiet_s)
    else $error("records closer than 40 ns");
  record_hold_a: assert property (!acq_we |-> $stable(acq_addr) && $stable(acq_data))
    else $error("record outputs moved without a record");
  record_addr_a: assert property (acq_we |-> acq_addr == exp_addr_reg)
    else $error("record address out of sequence");
endmodule

bind sitc_top sitc_top_assertions #(.NPODS(NPODS), .POD_W(POD_W), .DEPTH(DEPTH), .AW(AW)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .acq_we(acq_we),
  .acq_addr(acq_addr), .acq_data(acq_data));
